// >>> design/flash_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host
    import flash_host_pkg::*;
#(
    parameter int          PROT_WAIT = PROT_CYC,
    parameter int          UNP_WAIT  = UNP_CYC,
    parameter logic [7:0]  PROT_CMD  = 8'h60,
    parameter logic [7:0]  VER_CMD   = 8'h40
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        cmd_valid,
    input  wire logic [2:0]  cmd_op,
    input  wire logic [7:0]  cmd_sector,
    input  wire logic        byte_mode,
    input  wire logic        boot_top,
    input  wire logic        guard_release,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_fail,
    input  wire logic [7:0]  flash_dq_i,
    output logic [7:0]       flash_dq_o,
    output logic             flash_dq_oe,
    output logic [19:0]      flash_addr,
    output logic             flash_addr_lsb,
    output logic             flash_ce_b,
    output logic             flash_oe_b,
    output logic             flash_we_b,
    output logic             flash_byte_b,
    output logic             a9_vid_en,
    output logic             reset_vid_en,
    output logic             flash_reset_b,
    output logic             boot_guard_pin
);

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_SETTLE   = 4'b0001,
        S_RD       = 4'b0010,
        S_PROT_WR  = 4'b0011,
        S_PROT_DLY = 4'b0100,
        S_VER_WR   = 4'b0101,
        S_VER_RD   = 4'b0110,
        S_UNP_WR   = 4'b0111,
        S_UNP_DLY  = 4'b1000,
        S_HV_OFF   = 4'b1001,
        S_DONE     = 4'b1010
    } seq_state_t;

    typedef enum logic [1:0] {
        P_NONE   = 2'b00,
        P_PRE    = 2'b01,
        P_POST   = 2'b10
    } phase_t;

    cycle_if cyc ();

    seq_state_t  state_reg;
    phase_t      phase_reg;
    op_t         op_reg;
    logic [7:0]  sector_reg;
    logic [4:0]  group_reg;
    logic [4:0]  tries_reg;
    logic [19:0] wait_reg;
    logic        fail_reg;
    logic        issued_reg;
    logic        req_reg;
    logic        write_reg;
    logic [19:0] caddr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  result_reg;
    logic [7:0]  grp_hi;

    assign cyc.req   = req_reg;
    assign cyc.write = write_reg;
    assign cyc.addr  = caddr_reg;
    assign cyc.wdata = wdata_reg;

    // ----------------------------------------------------------------
    // Group representative addresses
    // ----------------------------------------------------------------
    // One address inside each protection group; bottom boot is the bitwise inverse of top boot
    function automatic logic [7:0] group_addr(input logic [4:0] g, input logic top);
        logic [7:0] a;
        a = 8'h00;
        case (g)
            5'h00:   a = 8'h00;
            5'h01:   a = 8'h08;
            5'h02:   a = 8'h20;
            5'h03:   a = 8'h40;
            5'h04:   a = 8'h60;
            5'h05:   a = 8'h80;
            5'h06:   a = 8'hA0;
            5'h07:   a = 8'hC0;
            5'h08:   a = 8'hE0;
            default: a = SINGLE_HI | {5'h00, 3'(g - 5'(SINGLE_BASE))};
        endcase
        group_addr = top ? a : ~a;
    endfunction : group_addr

    // Address with A6, A1, A0 taken from the a6, a1, a0 arguments and every other low bit held at zero
    function automatic logic [19:0] id_addr(input logic [7:0] hi, input logic a6,
                                            input logic a1, input logic a0);
        logic [19:0] a;
        a = {hi, 12'h000};
        a[ADDR_A6] = a6;
        a[ADDR_A1] = a1;
        a[ADDR_A0] = a0;
        id_addr = a;
    endfunction : id_addr

    assign grp_hi = (phase_reg == P_NONE) ? sector_reg : group_addr(group_reg, boot_top);

    // ----------------------------------------------------------------
    // Fixed pin levels and pins registered from byte_mode and guard_release
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_byte_b   <= 1'b1;
            flash_addr_lsb <= 1'b0;
            flash_reset_b  <= 1'b1;
            boot_guard_pin <= 1'b0;
        end else begin
            flash_byte_b   <= ~byte_mode;
            flash_addr_lsb <= 1'b0;
            flash_reset_b  <= 1'b1;
            boot_guard_pin <= guard_release;
        end
    end

    // ----------------------------------------------------------------
    // Operation sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= S_IDLE;
            phase_reg    <= P_NONE;
            op_reg       <= OP_MAKER;
            sector_reg   <= 8'h00;
            group_reg    <= 5'h00;
            tries_reg    <= 5'h00;
            wait_reg     <= 20'h00000;
            fail_reg     <= 1'b0;
            issued_reg   <= 1'b0;
            req_reg      <= 1'b0;
            write_reg    <= 1'b0;
            caddr_reg    <= 20'h00000;
            wdata_reg    <= 8'h00;
            result_reg   <= 8'h00;
            cmd_ready    <= 1'b1;
            rsp_valid    <= 1'b0;
            rsp_data     <= 8'h00;
            rsp_fail     <= 1'b0;
            a9_vid_en    <= 1'b0;
            reset_vid_en <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            req_reg   <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        op_reg     <= op_t'(cmd_op);
                        sector_reg <= cmd_sector;
                        cmd_ready  <= 1'b0;
                        fail_reg   <= 1'b0;
                        tries_reg  <= 5'h00;
                        group_reg  <= 5'h00;
                        phase_reg  <= (op_t'(cmd_op) == OP_UNPROTECT) ? P_PRE : P_NONE;
                        wait_reg   <= 20'(VID_CYC);
                        if (op_t'(cmd_op) == OP_PROTECT || op_t'(cmd_op) == OP_UNPROTECT) begin
                            reset_vid_en <= 1'b1;
                        end else begin
                            a9_vid_en <= 1'b1;
                        end
                        state_reg <= S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (wait_reg != 20'h00000) begin
                        wait_reg <= wait_reg - 20'h00001;
                    end else if (op_reg == OP_PROTECT) begin
                        state_reg <= S_PROT_WR;
                    end else if (op_reg == OP_UNPROTECT) begin
                        state_reg <= S_VER_WR;
                    end else begin
                        state_reg <= S_RD;
                    end
                end
                S_RD: begin
                    if (!issued_reg) begin
                        req_reg    <= 1'b1;
                        write_reg  <= 1'b0;
                        issued_reg <= 1'b1;
                        case (op_reg)
                            OP_MAKER:  caddr_reg <= id_addr(sector_reg, 1'b0, 1'b0, 1'b0);
                            OP_DEVICE: caddr_reg <= id_addr(sector_reg, 1'b0, 1'b0, 1'b1);
                            OP_CONT:   caddr_reg <= id_addr(8'h00, 1'b0, 1'b1, 1'b1);
                            default:   caddr_reg <= id_addr(sector_reg, 1'b0, 1'b1, 1'b0);
                        endcase
                    end else if (cyc.done) begin
                        issued_reg <= 1'b0;
                        result_reg <= cyc.rdata;
                        state_reg  <= S_HV_OFF;
                    end
                end
                S_PROT_WR: begin
                    if (!issued_reg) begin
                        req_reg    <= 1'b1;
                        write_reg  <= 1'b1;
                        issued_reg <= 1'b1;
                        caddr_reg  <= id_addr(grp_hi, 1'b0, 1'b1, 1'b0);
                        wdata_reg  <= PROT_CMD;
                    end else if (cyc.done) begin
                        issued_reg <= 1'b0;
                        wait_reg   <= 20'(PROT_WAIT);
                        state_reg  <= S_PROT_DLY;
                    end
                end
                S_PROT_DLY: begin
                    if (wait_reg != 20'h00000) begin
                        wait_reg <= wait_reg - 20'h00001;
                    end else begin
                        state_reg <= S_VER_WR;
                    end
                end
                S_VER_WR: begin
                    if (!issued_reg) begin
                        req_reg    <= 1'b1;
                        write_reg  <= 1'b1;
                        issued_reg <= 1'b1;
                        caddr_reg  <= id_addr(grp_hi, 1'b0, 1'b1, 1'b0);
                        wdata_reg  <= VER_CMD;
                    end else if (cyc.done) begin
                        issued_reg <= 1'b0;
                        state_reg  <= S_VER_RD;
                    end
                end
                S_VER_RD: begin
                    if (!issued_reg) begin
                        req_reg    <= 1'b1;
                        write_reg  <= 1'b0;
                        issued_reg <= 1'b1;
                        caddr_reg  <= id_addr(grp_hi, 1'b0, 1'b1, 1'b0);
                    end else if (cyc.done) begin
                        issued_reg <= 1'b0;
                        result_reg <= cyc.rdata;
                        if (phase_reg == P_POST) begin
                            // Every group must read clear after the unprotect pulse, which is issued at most MAX_TRIES times in all
                            if (cyc.rdata != PROT_CLR) begin
                                if (tries_reg == 5'(MAX_TRIES - 1)) begin
                                    fail_reg  <= 1'b1;
                                    state_reg <= S_HV_OFF;
                                end else begin
                                    tries_reg <= tries_reg + 5'h01;
                                    state_reg <= S_UNP_WR;
                                end
                            end else if (group_reg == 5'(GROUPS - 1)) begin
                                state_reg <= S_HV_OFF;
                            end else begin
                                group_reg <= group_reg + 5'h01;
                                state_reg <= S_VER_WR;
                            end
                        end else if (cyc.rdata == PROT_SET) begin
                            tries_reg <= 5'h00;
                            if (phase_reg == P_PRE && group_reg != 5'(GROUPS - 1)) begin
                                group_reg <= group_reg + 5'h01;
                                state_reg <= S_VER_WR;
                            end else if (phase_reg == P_PRE) begin
                                group_reg <= 5'h00;
                                state_reg <= S_UNP_WR;
                            end else begin
                                state_reg <= S_HV_OFF;
                            end
                        end else if (tries_reg == 5'(MAX_TRIES - 1)) begin
                            fail_reg  <= 1'b1;
                            state_reg <= S_HV_OFF;
                        end else begin
                            tries_reg <= tries_reg + 5'h01;
                            state_reg <= S_PROT_WR;
                        end
                    end
                end
                S_UNP_WR: begin
                    if (!issued_reg) begin
                        req_reg    <= 1'b1;
                        write_reg  <= 1'b1;
                        issued_reg <= 1'b1;
                        caddr_reg  <= id_addr(group_addr(5'h00, boot_top), 1'b1, 1'b1, 1'b0);
                        wdata_reg  <= PROT_CMD;
                        phase_reg  <= P_POST;
                    end else if (cyc.done) begin
                        issued_reg <= 1'b0;
                        group_reg  <= 5'h00;
                        wait_reg   <= 20'(UNP_WAIT);
                        state_reg  <= S_UNP_DLY;
                    end
                end
                S_UNP_DLY: begin
                    if (wait_reg != 20'h00000) begin
                        wait_reg <= wait_reg - 20'h00001;
                    end else begin
                        state_reg <= S_VER_WR;
                    end
                end
                S_HV_OFF: begin
                    // Dropping the high voltages restores array reads and stored protection
                    a9_vid_en    <= 1'b0;
                    reset_vid_en <= 1'b0;
                    state_reg    <= S_DONE;
                end
                S_DONE: begin
                    rsp_valid <= 1'b1;
                    rsp_data  <= result_reg;
                    rsp_fail  <= fail_reg;
                    cmd_ready <= 1'b1;
                    phase_reg <= P_NONE;
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle engine
    // ----------------------------------------------------------------
    flash_cycle u_cycle (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .cyc      (cyc.engine),
        .dq_i     (flash_dq_i),
        .dq_o     (flash_dq_o),
        .dq_oe    (flash_dq_oe),
        .addr_o   (flash_addr),
        .ce_b     (flash_ce_b),
        .oe_b     (flash_oe_b),
        .we_b     (flash_we_b)
    );

endmodule : flash_host
`default_nettype wire

// >>> design/flash_host_pkg.sv
package flash_host_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS        = 20;
    localparam int T_ACC_NS      = 70;
    localparam int T_WP_NS       = 50;
    localparam int T_VID_US      = 4;
    localparam int T_PROT_US     = 150;
    localparam int T_UNP_MS      = 15;
    localparam int SYNC_STAGES   = 2;
    localparam int ACC_CYC       = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int WP_CYC        = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int VID_CYC       = (T_VID_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PROT_CYC      = (T_PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int UNP_CYC       = (T_UNP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int MAX_TRIES     = 25;

    // ----------------------------------------------------------------
    // Address fields and codes
    // ----------------------------------------------------------------
    localparam int GROUPS        = 17;
    localparam int SINGLE_BASE   = 9;
    localparam int ADDR_A6       = 6;
    localparam int ADDR_A1       = 1;
    localparam int ADDR_A0       = 0;
    localparam logic [7:0] PROT_SET  = 8'h01;
    localparam logic [7:0] PROT_CLR  = 8'h00;
    localparam logic [7:0] SINGLE_HI = 8'hF8;

    typedef enum logic [2:0] {
        OP_MAKER     = 3'b000,
        OP_DEVICE    = 3'b001,
        OP_CONT      = 3'b010,
        OP_VERIFY    = 3'b011,
        OP_PROTECT   = 3'b100,
        OP_UNPROTECT = 3'b101
    } op_t;

endpackage : flash_host_pkg

// >>> design/cycle_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cycle_if;
    logic        req;
    logic        write;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;

    modport seq    (output req, output write, output addr, output wdata, input done, input rdata);
    modport engine (input req, input write, input addr, input wdata, output done, output rdata);
endinterface : cycle_if
`default_nettype wire

// >>> design/flash_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
    import flash_host_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    cycle_if.engine          cyc,
    input  wire logic [7:0]  dq_i,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    output logic [19:0]      addr_o,
    output logic             ce_b,
    output logic             oe_b,
    output logic             we_b
);

    typedef enum logic [1:0] {
        C_IDLE  = 2'b00,
        C_SETUP = 2'b01,
        C_PULSE = 2'b10,
        C_HOLD  = 2'b11
    } cyc_state_t;

    cyc_state_t  state_reg;
    logic [3:0]  cnt_reg;
    logic        wr_reg;
    logic [7:0]  dq_meta_reg;
    logic [7:0]  dq_sync_reg;

    // ----------------------------------------------------------------
    // Data pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_meta_reg <= 8'h00;
            dq_sync_reg <= 8'h00;
        end else begin
            dq_meta_reg <= dq_i;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= C_IDLE;
            cnt_reg   <= 4'h0;
            wr_reg    <= 1'b0;
            ce_b      <= 1'b1;
            oe_b      <= 1'b1;
            we_b      <= 1'b1;
            dq_oe     <= 1'b0;
            dq_o      <= 8'h00;
            addr_o    <= 20'h00000;
            cyc.done  <= 1'b0;
            cyc.rdata <= 8'h00;
        end else begin
            cyc.done <= 1'b0;
            case (state_reg)
                C_IDLE: begin
                    if (cyc.req) begin
                        // Address and chip select settle one cycle before any strobe
                        addr_o    <= cyc.addr;
                        dq_o      <= cyc.wdata;
                        wr_reg    <= cyc.write;
                        ce_b      <= 1'b0;
                        state_reg <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    if (wr_reg) begin
                        we_b    <= 1'b0;
                        dq_oe   <= 1'b1;
                        cnt_reg <= 4'(WP_CYC);
                    end else begin
                        oe_b    <= 1'b0;
                        cnt_reg <= 4'(ACC_CYC);
                    end
                    state_reg <= C_PULSE;
                end
                C_PULSE: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        if (!wr_reg) begin
                            cyc.rdata <= dq_sync_reg;
                        end
                        we_b      <= 1'b1;
                        oe_b      <= 1'b1;
                        state_reg <= C_HOLD;
                    end
                end
                C_HOLD: begin
                    // Data held past the rising strobe edge
                    ce_b      <= 1'b1;
                    dq_oe     <= 1'b0;
                    cyc.done  <= 1'b1;
                    state_reg <= C_IDLE;
                end
                default: begin
                    state_reg <= C_IDLE;
                end
            endcase
        end
    end

endmodule : flash_cycle
`default_nettype wire

// >>> testbench/flash_host_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_asserts (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        rsp_valid,
    input wire logic        byte_mode,
    input wire logic        guard_release,
    input wire logic        flash_byte_b,
    input wire logic        boot_guard_pin,
    input wire logic [19:0] flash_addr,
    input wire logic        flash_ce_b,
    input wire logic        flash_oe_b,
    input wire logic        flash_we_b,
    input wire logic        flash_dq_oe,
    input wire logic        a9_vid_en,
    input wire logic        reset_vid_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_WR_START: assert property ($fell(flash_we_b) |-> !flash_ce_b && flash_oe_b)
        else $error("write strobe without select");
    AST_WR_VID: assert property (!flash_we_b |-> reset_vid_en)
        else $error("write outside high voltage mode");
    AST_DQ_OE: assert property (flash_dq_oe |-> flash_oe_b && !flash_ce_b)
        else $error("data driven during read");
    AST_ID_READ: assert property (!flash_oe_b && a9_vid_en |-> flash_we_b && !flash_ce_b && !flash_addr[6])
        else $error("id read strobes bad");
    AST_BYTE: assert property (1'b1 |=> flash_byte_b == !$past(byte_mode))
        else $error("byte select wrong");
    AST_GUARD: assert property (1'b1 |=> boot_guard_pin == $past(guard_release))
        else $error("guard pin wrong");
    AST_VID_HOLD: assert property ($rose(a9_vid_en) |-> (a9_vid_en && flash_oe_b)[*8])
        else $error("read before voltage settles");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
endmodule : flash_host_asserts
bind flash_host flash_host_asserts i_chk (.core_clk, .rst_b, .rsp_valid, .byte_mode, .guard_release,
    .flash_byte_b, .boot_guard_pin, .flash_addr, .flash_ce_b, .flash_oe_b, .flash_we_b, .flash_dq_oe,
    .a9_vid_en, .reset_vid_en);
`default_nettype wire

// >>> testbench/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
package flash_dev_pkg;
    // Arbitrary identification values
    localparam logic [7:0] MAKER_ID = 8'h5A;
    localparam logic [7:0] DEV_ID   = 8'hC3;
    localparam logic [7:0] CONT_ID  = 8'h9E;
    // Arbitrary code for the command-register route to the identification codes
    localparam logic [7:0] ID_CMD   = 8'hA5;
    function automatic int grp(input logic [7:0] s, input logic top);
        logic [7:0] a;
        a = top ? s : ~s;
        if (a[7:3] == 5'h00) return 0;
        if (a[7:5] == 3'h0) return 1;
        if (a[7:5] != 3'h7) return int'(a[7:5]) + 1;
        if (a[7:3] != 5'h1F) return 8;
        return 9 + int'(a[2:0]);
    endfunction : grp
endpackage : flash_dev_pkg
module flash_dev_model
    import flash_dev_pkg::*;
(
    input  wire logic [19:0] flash_addr,
    input  wire logic        flash_ce_b,
    input  wire logic        flash_oe_b,
    input  wire logic        flash_we_b,
    input  wire logic        a9_vid_en,
    input  wire logic        reset_vid_en,
    input  wire logic        boot_top,
    input  wire logic [7:0]  flash_dq_o,
    output logic      [7:0]  flash_dq_i,
    output logic             early_unp
);
    logic [16:0] prot = '0;
    logic [7:0]  rd;
    logic        cmd_id = 1'b0;
    int          g;
    initial early_unp = 1'b0;
    assign g = grp(flash_addr[19:12], boot_top);
    always_comb begin
        case (flash_addr[1:0])
            2'b00: rd = MAKER_ID;
            2'b01: rd = DEV_ID;
            2'b11: rd = CONT_ID;
            default: rd = {7'h0, prot[g]};
        endcase
        if (!a9_vid_en && !reset_vid_en && !cmd_id) rd = ~flash_addr[7:0];
    end
    // A released bus never repeats the last byte
    assign flash_dq_i = (!flash_ce_b && !flash_oe_b) ? rd : ~rd;
    always @(posedge flash_we_b) begin
        if (!flash_ce_b && flash_oe_b && reset_vid_en) begin
            if (flash_addr[6]) begin
                early_unp <= early_unp | ~&prot;
                prot <= '0;
            end else if (flash_dq_o == 8'h60) prot[g] <= 1'b1;
        end
        // Any other command write without high voltage leaves the code mode
        if (!flash_ce_b && flash_oe_b && !reset_vid_en) cmd_id <= (flash_dq_o == ID_CMD);
    end
endmodule : flash_dev_model
`default_nettype wire

// >>> testbench/flash_host_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_test;
    import flash_host_pkg::*;
    import flash_dev_pkg::*;
    logic core_clk = 0, rst_b = 0, cmd_valid = 0, byte_mode = 0, boot_top = 1, guard_release = 0;
    logic [2:0] cmd_op = '0;
    logic [7:0] cmd_sector = '0, flash_dq_i, flash_dq_o, rsp_data, s;
    logic [19:0] flash_addr;
    logic cmd_ready, rsp_valid, rsp_fail, flash_dq_oe, flash_addr_lsb, flash_ce_b, flash_oe_b, flash_we_b;
    logic flash_byte_b, a9_vid_en, reset_vid_en, flash_reset_b, boot_guard_pin, early_unp;
    logic [16:0] prot_exp;
    int failures = 0, n_tests = 0;
    flash_host #(.PROT_WAIT(20), .UNP_WAIT(20)) i_flash_host (.core_clk, .rst_b, .cmd_valid, .cmd_op,
        .cmd_sector, .byte_mode, .boot_top, .guard_release, .cmd_ready, .rsp_valid, .rsp_data, .rsp_fail,
        .flash_dq_i, .flash_dq_o, .flash_dq_oe, .flash_addr, .flash_addr_lsb, .flash_ce_b, .flash_oe_b,
        .flash_we_b, .flash_byte_b, .a9_vid_en, .reset_vid_en, .flash_reset_b, .boot_guard_pin);
    flash_dev_model i_flash_dev_model (.flash_addr, .flash_ce_b, .flash_oe_b, .flash_we_b, .a9_vid_en,
        .reset_vid_en, .boot_top, .flash_dq_o, .flash_dq_i, .early_unp);
    initial forever #10 core_clk = ~core_clk;
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic run(input logic [2:0] op, input logic [7:0] sec);
        int n;
        @(negedge core_clk);
        {cmd_valid, cmd_op, cmd_sector} = {1'b1, op, sec};
        {byte_mode, guard_release} = 2'($urandom);
        do @(posedge core_clk); while (cmd_ready !== 1'b1);
        @(negedge core_clk) cmd_valid = 1'b0;
        for (n = 0; n < 20000 && rsp_valid !== 1'b1; n++) @(posedge core_clk) #1;
        if (n == 20000) failures++;
        if (op == 3'h4) prot_exp[grp(sec, boot_top)] = 1'b1;
        if (op == 3'h5) prot_exp = '0;
        check8({7'h0, rsp_fail}, 8'h00);
        check8({4'h0, flash_reset_b, flash_addr_lsb, a9_vid_en, reset_vid_en}, 8'h08);
        case (op)
            3'h0: check8(rsp_data, MAKER_ID);
            3'h1: check8(rsp_data, DEV_ID);
            3'h2: check8(rsp_data, CONT_ID);
            default: check8(rsp_data, {7'h0, prot_exp[grp(sec, boot_top)]});
        endcase
    endtask : run
    task automatic results;
        $display("%0d checks, %0d failures", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        #1800000;
        failures++;
        results();
    end
    initial begin
        void'($urandom(32'hA83F8893));
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) rst_b = 1'b1;
        for (int t = 1; t >= 0; t--) begin
            @(negedge core_clk) boot_top = t[0];
            prot_exp = '0;
            for (int op = 0; op < 3; op++) run(op[2:0], 8'($urandom));
            run(3'h3, 8'($urandom));
            for (int k = 0; k < 6; k++) begin
                s = (k < 2) ? {8{k[0]}} : 8'($urandom);
                run(3'h4, s);
                run(3'h3, s ^ 8'($urandom % 4));
                run(3'h6, s ^ 8'h20);
            end
            run(3'h5, 8'($urandom));
            run(3'h3, s);
            check8({7'h0, early_unp}, 8'h00);
            $display("boot_top %0d pass done", t);
        end
        results();
    end
endmodule : flash_host_test
`default_nettype wire
